// ==== src/lads_map.svh ====
// Register offsets, field positions, reset values and codes of the link-analysis diagnostics block.
// Assumes nothing; definitions only, included by bare name.
`ifndef LADS_MAP_SVH
`define LADS_MAP_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define LADS_IDX_DIAG    8'h1E
`define LADS_IDX_CTRL    8'h20
`define LADS_IDX_IRQ_STS 8'h21
`define LADS_IDX_IRQ_CLR 8'h22
`define LADS_IDX_IRQ_EN  8'h23

// ----------------------------------------
// Diagnostics register fields
// ----------------------------------------
`define LADS_RSV_HI      15
`define LADS_RSV_LO      12
`define LADS_SWAP_BIT    11
`define LADS_LEN_HI      10
`define LADS_LEN_LO      5
`define LADS_POL_HI      4
`define LADS_POL_LO      1
`define LADS_SKEW_BIT    0
`define LADS_DIAG_RST    16'h0000
`define LADS_RW_MASK     16'h0FFF

// ----------------------------------------
// Cable length codes
// ----------------------------------------
`define LADS_LEN_STEP_M  9'h005
`define LADS_LEN_MAX     6'h1F
`define LADS_LEN_INVALID 6'h3F

// ----------------------------------------
// Control and interrupt fields
// ----------------------------------------
`define LADS_CTRL_EN_BIT  0
`define LADS_CTRL_SEL_BIT 1
`define LADS_CTRL_RST     2'h0
`define LADS_EV_SWAP      0
`define LADS_EV_SKEW      1
`define LADS_EV_LENBAD    2
`define LADS_EV_POL       3
`define LADS_EV_RST       4'h0

// ----------------------------------------
// Pair codes
// ----------------------------------------
`define LADS_PAIR_A 2'h0
`define LADS_PAIR_D 2'h3

`endif

// ==== src/lads_pkg.sv ====
// Types shared by the link-analysis diagnostics block.
// Assumes the map header sits beside it.
`default_nettype none

package lads_pkg;
	// Line speed reported by the transceiver core
	typedef enum logic [1:0] {
		LADS_SPD_10,
		LADS_SPD_100,
		LADS_SPD_1000
	} lads_speed_e;

	// Pair identity, A = 0 through D = 3
	typedef logic [1:0] lads_pair_t;
	typedef lads_pair_t [3:0] lads_pairs_t;
endpackage

`default_nettype wire

// ==== src/lads_map_if.sv ====
// Carrier between the diagnostics top and its pair mapper.
// Assumes lads_pkg compiled first.
`default_nettype none

interface lads_map_if;
	logic                  mdix;    // MDI-X crossover selected
	logic                  cd_swap; // Pairs C and D swapped
	lads_pkg::lads_pairs_t tx_pair; // Transmit pair per line channel
	lads_pkg::lads_pairs_t rx_pair; // Receive pair per line channel

	modport mapper (input mdix, input cd_swap, output tx_pair, output rx_pair);
	modport user   (output mdix, output cd_swap, input tx_pair, input rx_pair);
endinterface

`default_nettype wire

// ==== src/lads_mapper.sv ====
// Pair mapper: transmit and receive pair of each line channel.
// Assumes a single 1000Base-T link context; purely combinational.
`default_nettype none

module lads_mapper (
	lads_map_if.mapper m // Mode in, mapping out
);
	import lads_pkg::*;

	// ----------------------------------------
	// Per line channel mapping
	// ----------------------------------------
	genvar c;
	generate
		for (c = 0; c < 4; c++) begin : g_ch
			localparam lads_pair_t CH  = lads_pair_t'(c);
			localparam lads_pair_t XCH = lads_pair_t'(c ^ 1);
			wire upper = (c >= 2);
			// Transmit never moves with the C/D swap
			assign m.tx_pair[c] = m.mdix ? XCH : CH;
			// Swapped C/D flips the receive sense on channels 2 and 3
			assign m.rx_pair[c] = (m.cd_swap && upper) ? (m.mdix ? XCH : CH)
			                                            : (m.mdix ? CH : XCH);
		end
	endgenerate
endmodule

`default_nettype wire

// ==== src/lads_top.sv ====
// Link-analysis diagnostics register block with Avalon-MM slave and interrupt.
// Assumes core status inputs come from logic on core_clk; no synchronisers needed.
//
// What this block does
// - Bit 11 reads 1 when pairs C and D are found swapped, 1000Base-T.
// - Bits 10:5 give cable length while linked, code times 5 metres, 0 to 155.
// - Codes 0x20 to 0x3e are reserved and never reported.
// - An estimate that cannot be made validly, as on 10Base-T, returns 0x3f.
// - Bits 4..1 give polarity of pairs D, C, B, A in 1000Base-T, else 0; 1 normal, 0 inverted.
// - Bit 0 flags excessive skew when the descrambler fails to lock, 1000Base-T.
// - Without swap, MDI and MDI-X give the fixed channel pair mapping.
// - With C/D swapped, transmit unchanged, receive on channels 2 and 3 changes.
// - The same address shows the TDR view unless link analysis is both enabled and selected.
//
// Implementation choice: the Avalon-MM slave port.
`include "lads_map.svh"
`default_nettype none

module lads_top (
	input  wire logic                 core_clk,        // Clock, 100 MHz
	input  wire logic                 nrst,            // Synchronous reset, active low
	input  wire logic                 ce,              // Clock enable, freezes all state
	// Avalon-MM slave
	input  wire logic [9:0]           avs_address,     // Byte address
	input  wire logic                 avs_read,        // Read request
	input  wire logic                 avs_write,       // Write request
	input  wire logic [31:0]          avs_writedata,   // Write data
	input  wire logic [3:0]           avs_byteenable,  // Byte lanes
	output logic      [31:0]          avs_readdata,    // Read data
	output logic                      avs_waitrequest, // Stall
	// Transceiver core status
	input  wire logic                 link_up,         // Link active
	input  wire lads_pkg::lads_speed_e link_speed,     // Resolved speed
	input  wire logic                 mdix_active,     // Crossover resolved to MDI-X
	input  wire logic                 cd_swap_det,     // C/D swap found
	input  wire logic [3:0]           pol_normal,      // Polarity per pair D..A
	input  wire logic                 descr_locked,    // Descrambler acquired
	input  wire logic [8:0]           len_est_m,       // Length estimate, metres
	input  wire logic                 len_est_ok,      // Estimate is trustworthy
	input  wire logic                 est_update,      // Refresh pulse
	input  wire logic [15:0]          tdr_view,        // TDR view of same address
	// Outputs
	output lads_pkg::lads_pairs_t     line_tx_pair,    // Tx pair per line channel
	output lads_pkg::lads_pairs_t     line_rx_pair,    // Rx pair per line channel
	output logic                      irq              // Level interrupt
);
	import lads_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [15:0] diag;
	logic [1:0]  ctrl;
	logic [3:0]  irq_sts;
	logic [3:0]  irq_en;
	logic [15:0] next_diag;
	logic [3:0]  next_sts;
	logic [31:0] next_rdata;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire req      = avs_read | avs_write;
	wire accept   = req & ~avs_waitrequest;
	wire wr_fire  = accept & avs_write;
	wire hit_diag = (avs_address == {`LADS_IDX_DIAG, 2'b00});
	wire hit_ctrl = (avs_address == {`LADS_IDX_CTRL, 2'b00});
	wire hit_sts  = (avs_address == {`LADS_IDX_IRQ_STS, 2'b00});
	wire hit_clr  = (avs_address == {`LADS_IDX_IRQ_CLR, 2'b00});
	wire hit_en   = (avs_address == {`LADS_IDX_IRQ_EN, 2'b00});
	wire [15:0] wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [3:0]  clr_bits = (wr_fire && hit_clr && avs_byteenable[0]) ? avs_writedata[3:0] : 4'h0;

	// Link analysis view only with diagnostics on and mode selected
	wire la_view = ctrl[`LADS_CTRL_EN_BIT] & ctrl[`LADS_CTRL_SEL_BIT];

	// ----------------------------------------
	// Hardware view of the link
	// ----------------------------------------
	wire        gig      = link_up && (link_speed == LADS_SPD_1000);
	wire [8:0]  len_q    = len_est_m / `LADS_LEN_STEP_M;
	wire        len_bad  = !link_up || !len_est_ok || (link_speed == LADS_SPD_10);
	wire [5:0]  len_code = len_bad ? `LADS_LEN_INVALID
	                     : (len_q > 9'(`LADS_LEN_MAX)) ? `LADS_LEN_MAX
	                     : len_q[5:0];
	wire        hw_swap  = gig & cd_swap_det;
	wire [3:0]  hw_pol   = gig ? pol_normal : 4'h0;
	wire        hw_skew  = gig & ~descr_locked;
	wire [15:0] hw_diag  = {4'h0, hw_swap, len_code, hw_pol, hw_skew};

	// Events raised when a refresh changes the view
	wire [3:0] ev;
	assign ev[`LADS_EV_SWAP]   = est_update & hw_swap & ~diag[`LADS_SWAP_BIT];
	assign ev[`LADS_EV_SKEW]   = est_update & hw_skew & ~diag[`LADS_SKEW_BIT];
	assign ev[`LADS_EV_LENBAD] = est_update & (len_code == `LADS_LEN_INVALID) &
	                             (diag[`LADS_LEN_HI:`LADS_LEN_LO] != `LADS_LEN_INVALID);
	assign ev[`LADS_EV_POL]    = est_update & (hw_pol != diag[`LADS_POL_HI:`LADS_POL_LO]);

	// ----------------------------------------
	// Next register values
	// ----------------------------------------
	always_comb begin
		next_diag = diag;
		if (est_update) begin
			next_diag = hw_diag;
		end else if (wr_fire && hit_diag && la_view) begin
			// Reserved bits never take write data
			next_diag = (diag & ~(wmask & `LADS_RW_MASK)) |
			            (avs_writedata[15:0] & wmask & `LADS_RW_MASK);
		end
	end

	// Set wins over a clear in the same cycle
	assign next_sts = (irq_sts & ~clr_bits) | ev;

	// Read data selection
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_diag) begin
			next_rdata = {16'h0000, la_view ? diag : tdr_view};
		end else if (hit_ctrl) begin
			next_rdata = {30'h0, ctrl};
		end else if (hit_sts) begin
			next_rdata = {28'h0, irq_sts};
		end else if (hit_en) begin
			next_rdata = {28'h0, irq_en};
		end
	end

	// ----------------------------------------
	// Pair mapping
	// ----------------------------------------
	lads_map_if mif ();
	assign mif.mdix    = mdix_active;
	assign mif.cd_swap = diag[`LADS_SWAP_BIT];

	lads_mapper u_map (
		.m (mif.mapper)
	);

	// ----------------------------------------
	// Bus handshake: one wait cycle per access
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else if (ce) begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (req && avs_waitrequest && avs_read) begin
				avs_readdata <= next_rdata;
			end
		end
	end

	// Diagnostics register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			diag <= `LADS_DIAG_RST;
		end else if (ce) begin
			diag <= next_diag;
		end
	end

	// Control register
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctrl <= `LADS_CTRL_RST;
		end else if (ce && wr_fire && hit_ctrl && avs_byteenable[0]) begin
			ctrl <= avs_writedata[1:0];
		end
	end

	// Interrupt status and enable
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			irq_sts <= `LADS_EV_RST;
			irq_en  <= `LADS_EV_RST;
		end else if (ce) begin
			irq_sts <= next_sts;
			if (wr_fire && hit_en && avs_byteenable[0]) begin
				irq_en <= avs_writedata[3:0];
			end
		end
	end

	// Registered outputs
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			irq          <= 1'b0;
			line_tx_pair <= '0;
			line_rx_pair <= '0;
		end else if (ce) begin
			irq          <= |(next_sts & irq_en);
			line_tx_pair <= mif.tx_pair;
			line_rx_pair <= mif.rx_pair;
		end
	end
endmodule

`default_nettype wire

// ==== test/lads_checker.sv ====
// Port checker for the diagnostics register block.
// Assumes ce held high; bound to lads_top after the module.
`default_nettype none
module lads_checker (
	input wire logic	core_clk,	// Clock
	input wire logic	nrst,	// Sync reset, low
	input wire logic [9:0]	avs_address,	// Byte address
	input wire logic	avs_read,	// Read request
	input wire logic	avs_write,	// Write request
	input wire logic [31:0]	avs_writedata,	// Write data
	input wire logic [31:0]	avs_readdata,	// Read data
	input wire logic	avs_waitrequest,	// Stall
	input wire logic	mdix_active,	// Crossover
	input wire lads_pkg::lads_pairs_t	line_tx_pair,	// Tx pairs
	input wire lads_pkg::lads_pairs_t	line_rx_pair,	// Rx pairs
	input wire logic	irq	// Interrupt
);
	timeunit 1ns / 1ns;
	import lads_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// Answer cycle and unmapped decode
	wire ans = !avs_waitrequest;
	wire unm = !(avs_address inside {10'h078, 10'h080, 10'h084, 10'h088, 10'h08C});
	// Bus steps
	sequence rd_unm; avs_read && avs_waitrequest && unm ##1 ans; endsequence
	sequence en_off; avs_write && avs_waitrequest && avs_address == 10'h08C && avs_writedata[3:0] == 4'h0 ##1 ans;
	endsequence
	wait_pulse_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest) else $error("wait low too long");
	req_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> ans) else $error("no answer");
	rst_idle_a: assert property ($rose(nrst) |-> avs_waitrequest && !irq && avs_readdata == 32'h0) else $error("reset");
	tx_map_a: assert property ($past(nrst) |-> line_tx_pair == ($past(mdix_active) ? 8'hB1 : 8'hE4))
		else $error("tx map");
	rx_low_a: assert property ($past(nrst) |-> line_rx_pair[1:0] == ($past(mdix_active) ? 4'h4 : 4'h1))
		else $error("rx map low");
	// Pair outputs still hold their reset value at the first edge after release
	rx_cd_a: assert property ($past(nrst) |-> line_rx_pair[3:2] == 4'hB || line_rx_pair[3:2] == 4'hE)
		else $error("rx cd");
	read_upper_a: assert property (ans |-> avs_readdata[31:16] == 16'h0) else $error("upper half");
	unmapped_zero_a: assert property (rd_unm |-> avs_readdata == 32'h0) else $error("unmapped read");
	irq_mask_a: assert property (en_off |-> ##2 !irq) else $error("masked irq");
endmodule
bind lads_top lads_checker u_chk (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_readdata, .avs_waitrequest, .mdix_active, .line_tx_pair, .line_rx_pair, .irq);
`default_nettype wire

// ==== test/lads_core_model.sv ====
// Transceiver core status model feeding the block.
// Assumes the bench sets a scene word and pulses go.
`default_nettype none
module lads_core_model (
	input wire logic [19:0]	sc,	// Scene word
	input wire logic	go,	// Refresh pulse
	output logic	link_up,	// Link active
	output lads_pkg::lads_speed_e	link_speed,	// Speed
	output logic	mdix_active,	// Crossover
	output logic	cd_swap_det,	// C/D swap
	output logic [3:0]	pol_normal,	// Polarity D..A
	output logic	descr_locked,	// Descrambler lock
	output logic [8:0]	len_est_m,	// Length metres
	output logic	len_est_ok,	// Estimate valid
	output logic	est_update	// Load pulse
);
	timeunit 1ns / 1ns;
	import lads_pkg::*;
	// Status levels straight from the scene, refresh pulse from go
	assign link_speed = lads_speed_e'(sc[2:1]);
	assign {len_est_ok, len_est_m, descr_locked} = sc[19:9];
	assign {pol_normal, cd_swap_det, mdix_active, link_up} = {sc[8:3], sc[0]};
	assign est_update = go;
endmodule
`default_nettype wire

// ==== test/lads_top_test.sv ====
// Self-checking bench of the diagnostics block.
// Assumes the checker bind and core model compiled first.
`default_nettype none
module lads_top_test;
	timeunit 1ns / 1ns;
	import lads_pkg::*;
	logic core_clk = 0, nrst = 0, ce = 1, avs_read = 0, avs_write = 0, go = 0;
	logic [9:0] avs_address = 10'h000;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [3:0] avs_byteenable = 4'hF, sts, en, ev;
	logic avs_waitrequest, irq;
	logic [19:0] sc = 20'h0, s;
	logic [15:0] tdr_view = 16'h5A3C, old, nw;
	lads_pairs_t line_tx_pair, line_rx_pair;
	wire logic link_up, mdix_active, cd_swap_det, descr_locked, len_est_ok, est_update;
	wire lads_speed_e link_speed;
	wire logic [3:0] pol_normal;
	wire logic [8:0] len_est_m;
	int errors = 0, checked = 0, cyc = 0, seed = 81, i;
	lads_top u_dut (.*);
	lads_core_model u_core (.*);
	// Clock and hang guard
	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			close_out();
		end
	end
	task automatic close_out();
		if (errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("unexpected %0t got %h exp %h", $time, g, e);
		end
	endtask
	// One bus access, held until the rising edge that samples waitrequest low
	task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge core_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		// Read data taken and request released at that same edge
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Expected diagnostics word for a scene
	function automatic logic [15:0] exp_diag(logic [19:0] x);
		logic g;
		logic [5:0] l;
		g = x[0] && x[2:1] == 2'h2;
		l = (!x[0] || !x[19] || x[2:1] == 2'h0) ? 6'h3F : (x[18:10] > 9'h09B) ? 6'h1F : 6'(x[18:10] / 5);
		return {4'h0, g & x[4], l, g ? x[8:5] : 4'h0, g & !x[9]};
	endfunction
	// Main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		bus(0, 10'h080, 0, q); chk(q, 0);
		bus(0, 10'h078, 0, q); chk(q, {16'h0, tdr_view});
		bus(1, 10'h080, 3, q); bus(0, 10'h080, 0, q); chk(q, 3);
		sts = 4'h0;
		old = 16'h0;
		for (i = 0; i < 40; i++) begin
			s = $random(seed);
			if (s[2:1] == 2'h3) s[2:1] = 2'h2;
			if (i < 4) s = {1'b1, i == 0 ? 9'h000 : i == 1 ? 9'h09B : i == 2 ? 9'h0A0 : 9'h1FF, s[9:3], 3'h5};
			if (i == 4) s[2:1] = 2'h0;
			en = $random(seed);
			bus(1, 10'h08C, {28'h0, en}, q);
			@(posedge core_clk);
			sc <= s;
			go <= 1'b1;
			@(posedge core_clk);
			go <= 1'b0;
			nw = exp_diag(s);
			ev = {nw[4:1] != old[4:1], nw[10:5] == 6'h3F && old[10:5] != 6'h3F, nw[0] & !old[0], nw[11] & !old[11]};
			sts = sts | ev;
			bus(0, 10'h078, 0, q); chk(q, {16'h0, nw});
			chk({24'h0, line_tx_pair}, s[3] ? 32'hB1 : 32'hE4);
			chk({24'h0, line_rx_pair}, s[3] ? (nw[11] ? 32'hB4 : 32'hE4) : (nw[11] ? 32'hE1 : 32'hB1));
			bus(0, 10'h084, 0, q); chk(q, {28'h0, sts});
			chk({31'h0, irq}, {31'h0, |(sts & en)});
			bus(1, 10'h088, 32'hF, q);
			sts = 4'h0;
			old = nw;
		end
		bus(0, 10'h088, 0, q); chk(q, 0);
		bus(1, 10'h078, 32'hFFFF, q); bus(0, 10'h078, 0, q); chk(q, 32'h0FFF);
		bus(1, 10'h3FC, 32'hFFFF, q); bus(0, 10'h3FC, 0, q); chk(q, 0);
		bus(1, 10'h08C, 0, q);
		bus(1, 10'h080, 1, q); bus(0, 10'h078, 0, q); chk(q, {16'h0, tdr_view});
		close_out();
	end
endmodule
`default_nettype wire
